/* File: reset_pin_filter_and_output.sv */
// Module: reset sequencer driving the push-pull reset output
`timescale 1ns/1ps
module reset_pin_filter_and_output #(
    parameter int unsigned HOLD = rst_pkg::HOLD_CYCLES
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic RESET_IN_N,
    input wire logic INT_RESET_REQ,
    input wire logic INT_RESET_NOWKP,
    input wire logic WEAK_PULL_CONFIG_PIN,
    input wire logic BOOT_CONFIG_PIN,
    output logic RESET_OUT_N,
    output logic RESET_OUT_OE,
    output logic INTERNAL_RESET,
    output logic [rst_pkg::ST_W-1:0] RESET_STATUS_REG,
    output logic BOOT_MODE
);
    rst_if ev ();
    rst_filter u_filt (
        .clk(MCLK),
        .rst_n(NRST),
        .pin_n(RESET_IN_N),
        .ev(ev)
    );

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic wk1_q, wk2_q, bt1_q, bt2_q;
    logic wk1_d, wk2_d, bt1_d, bt2_d;

    always_comb begin
        wk1_d = WEAK_PULL_CONFIG_PIN;
        wk2_d = wk1_q;
        bt1_d = BOOT_CONFIG_PIN;
        bt2_d = bt1_q;
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            wk1_q <= 1'b0;
            wk2_q <= 1'b0;
            bt1_q <= 1'b0;
            bt2_q <= 1'b0;
        end else begin
            wk1_q <= wk1_d;
            wk2_q <= wk2_d;
            bt1_q <= bt1_d;
            bt2_q <= bt2_d;
        end
    end

    // ----------------------------------------
    // Counter helpers
    // ----------------------------------------
    function automatic logic [rst_pkg::CNT_W-1:0] count_up(input logic [rst_pkg::CNT_W-1:0] c);
        return c + 8'h01;
    endfunction

    function automatic logic at_count(input logic [rst_pkg::CNT_W-1:0] c, input int unsigned n);
        return c == 8'(n - 1);
    endfunction

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    rst_pkg::seq_e st_q, st_d;
    logic [rst_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic start, src_ext;
    logic assert_out, capture, release_out, in_hold;

    always_comb begin
        src_ext = ev.req;
        start = ev.req | INT_RESET_REQ;
        st_d = st_q;
        cnt_d = cnt_q;
        assert_out = 1'b0;
        capture = 1'b0;
        release_out = 1'b0;
        in_hold = 1'b0;
        if (start) begin
            st_d = rst_pkg::DELAY;
            cnt_d = 8'h00;
        end else begin
            case (st_q)
                rst_pkg::IDLE: begin
                    cnt_d = 8'h00;
                end
                rst_pkg::DELAY: begin
                    cnt_d = count_up(cnt_q);
                    if (at_count(cnt_q, rst_pkg::OUT_DELAY_CYCLES)) begin
                        assert_out = 1'b1;
                        st_d = rst_pkg::HOLD;
                        cnt_d = 8'h00;
                    end
                end
                rst_pkg::HOLD: begin
                    in_hold = 1'b1;
                    cnt_d = count_up(cnt_q);
                    if (ev.low) begin
                        cnt_d = 8'h00;
                    end else if (at_count(cnt_q, HOLD - rst_pkg::WKP_SAMPLE_BEFORE)) begin
                        capture = 1'b1;
                        st_d = rst_pkg::RELEASE;
                        cnt_d = 8'h00;
                    end
                end
                rst_pkg::RELEASE: begin
                    cnt_d = count_up(cnt_q);
                    if (at_count(cnt_q, rst_pkg::WKP_SAMPLE_BEFORE)) begin
                        release_out = 1'b1;
                        st_d = rst_pkg::IDLE;
                        cnt_d = 8'h00;
                    end
                end
                default: begin
                    st_d = rst_pkg::IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            st_q <= rst_pkg::IDLE;
            cnt_q <= 8'h00;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------
    // Reset output and internal reset
    // ----------------------------------------
    logic out_n_q, out_n_d, irst_q, irst_d, oe_q, oe_d;

    always_comb begin
        out_n_d = out_n_q;
        irst_d = irst_q;
        oe_d = 1'b1;
        if (start) begin
            irst_d = 1'b1;
        end else if (assert_out) begin
            out_n_d = 1'b0;
        end else if (release_out) begin
            out_n_d = 1'b1;
            irst_d = 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            out_n_q <= 1'b1;
            irst_q <= 1'b0;
            oe_q <= 1'b1;
        end else begin
            out_n_q <= out_n_d;
            irst_q <= irst_d;
            oe_q <= oe_d;
        end
    end

    // ----------------------------------------
    // Reset status and boot mode
    // ----------------------------------------
    logic boot_q, boot_d, nowkp_q, nowkp_d;
    logic [rst_pkg::ST_W-1:0] stat_q, stat_d;

    always_comb begin
        boot_d = boot_q;
        nowkp_d = nowkp_q;
        stat_d = stat_q;
        if (ev.glitch) begin
            stat_d[rst_pkg::ST_GLITCH_BIT] = 1'b1;
        end
        if (start) begin
            nowkp_d = ~src_ext & INT_RESET_NOWKP;
            stat_d[rst_pkg::ST_EXT_BIT] = src_ext;
            stat_d[rst_pkg::ST_INT_BIT] = ~src_ext;
        end else if (in_hold) begin
            boot_d = bt2_q;
            stat_d[rst_pkg::ST_BOOT_BIT] = bt2_q;
            if (capture) begin
                if (!nowkp_q) begin
                    stat_d[rst_pkg::ST_WKP_BIT] = wk2_q;
                end
                stat_d[rst_pkg::ST_NOWKP_BIT] = nowkp_q;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            boot_q <= 1'b0;
            nowkp_q <= 1'b0;
            stat_q <= rst_pkg::ST_RESET;
        end else begin
            boot_q <= boot_d;
            nowkp_q <= nowkp_d;
            stat_q <= stat_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign RESET_OUT_N = out_n_q;
    assign RESET_OUT_OE = oe_q;
    assign INTERNAL_RESET = irst_q;
    assign RESET_STATUS_REG = stat_q;
    assign BOOT_MODE = boot_q;
endmodule

/* File: rst_pkg.sv */
// Package: reset pin filter constants and states
package rst_pkg;
    // ----------------------------------------
    // Timing counts
    // ----------------------------------------
    localparam int unsigned ASSERT_CYCLES = 10;
    localparam int unsigned GLITCH_CYCLES = 2;
    localparam int unsigned OUT_DELAY_CYCLES = 4;
    localparam int unsigned HOLD_CYCLES = 16;
    localparam int unsigned WKP_SAMPLE_BEFORE = 4;
    localparam int unsigned CNT_W = 8;
    // ----------------------------------------
    // Reset status field positions and reset values
    // ----------------------------------------
    localparam int unsigned ST_W = 6;
    localparam int unsigned ST_EXT_BIT = 0;
    localparam int unsigned ST_INT_BIT = 1;
    localparam int unsigned ST_WKP_BIT = 2;
    localparam int unsigned ST_BOOT_BIT = 3;
    localparam int unsigned ST_GLITCH_BIT = 4;
    localparam int unsigned ST_NOWKP_BIT = 5;
    localparam logic [5:0] ST_RESET = 6'h00;
    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {IDLE, DELAY, HOLD, RELEASE} seq_e;
endpackage

/* File: rst_if.sv */
// Interface: filtered pin events between filter and sequencer
`timescale 1ns/1ps
interface rst_if;
    logic req;
    logic low;
    logic glitch;
    modport filt (output req, output low, output glitch);
    modport seq (input req, input low, input glitch);
endinterface

/* File: rst_filter.sv */
// Module: reset pin synchroniser, low-time filter and glitch detector
`timescale 1ns/1ps
module rst_filter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin_n,
    rst_if.filt ev
);
    logic s1_q, s2_q, s1_d, s2_d;
    logic [rst_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic req_q, req_d, gl_q, gl_d;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s1_d = pin_n;
        s2_d = s1_q;
        req_d = 1'b0;
        gl_d = 1'b0;
        cnt_d = cnt_q;
        if (!s2_q) begin
            if (cnt_q != 8'hFF) begin
                cnt_d = cnt_q + 8'h01;
            end
            if (cnt_q == 8'(rst_pkg::ASSERT_CYCLES - 1)) begin
                req_d = 1'b1;
            end
        end else begin
            cnt_d = 8'h00;
            if (cnt_q > 8'(rst_pkg::GLITCH_CYCLES) && cnt_q < 8'(rst_pkg::ASSERT_CYCLES)) begin
                gl_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            cnt_q <= 8'h00;
            req_q <= 1'b0;
            gl_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            cnt_q <= cnt_d;
            req_q <= req_d;
            gl_q <= gl_d;
        end
    end

    assign ev.req = req_q;
    assign ev.low = ~s2_q;
    assign ev.glitch = gl_q;
endmodule

/* File: rst_checker.sv */
// Checker: reset pin filter assertions
`timescale 1ns/1ps
module rst_checker #(parameter int unsigned HOLD = 10) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic RESET_IN_N,
    input wire logic INT_RESET_REQ,
    input wire logic WEAK_PULL_CONFIG_PIN,
    input wire logic BOOT_CONFIG_PIN,
    input wire logic RESET_OUT_N,
    input wire logic RESET_OUT_OE,
    input wire logic INTERNAL_RESET,
    input wire logic [rst_pkg::ST_W-1:0] RESET_STATUS_REG
);
    // ----
    // Low run tracker
    // ----
    logic [3:0] run_q, run_d;
    logic long_q, long_d;
    always_comb begin
        run_d = RESET_IN_N ? 4'h0 : run_q + 4'(run_q != 4'hF);
        long_d = !INTERNAL_RESET && (long_q || (!RESET_IN_N && run_q >= 4'h9));
    end
    always_ff @(posedge MCLK) begin
        run_q <= NRST ? run_d : 4'h0;
        long_q <= NRST && long_d;
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    sequence s_late;
        RESET_OUT_N ##4 !RESET_OUT_N;
    endsequence
    AST_PUSH_PULL: assert property (RESET_OUT_OE)
        else $error("oe low");
    AST_OUT_DELAY: assert property ($rose(INTERNAL_RESET) |-> s_late)
        else $error("out delay");
    AST_INT_SRC: assert property (INT_RESET_REQ |=> INTERNAL_RESET)
        else $error("int source");
    AST_FILTER: assert property ($rose(INTERNAL_RESET) |-> long_q || $past(INT_RESET_REQ))
        else $error("short reset");
    AST_RELEASE: assert property ($rose(RESET_OUT_N) |-> $fell(INTERNAL_RESET))
        else $error("release");
    AST_MIN_LOW: assert property ($fell(RESET_OUT_N) |-> (!RESET_OUT_N)[*8])
        else $error("low time");
    AST_WKP: assert property ($rose(RESET_OUT_N) && !RESET_STATUS_REG[5]
        |-> RESET_STATUS_REG[2] == $past(WEAK_PULL_CONFIG_PIN, 6))
        else $error("weak pull");
    AST_BOOT: assert property ($rose(RESET_OUT_N) |-> RESET_STATUS_REG[3] == $past(BOOT_CONFIG_PIN, 6))
        else $error("boot");
endmodule
bind reset_pin_filter_and_output rst_checker #(.HOLD(HOLD)) chk (.*);

/* File: board_supervisor.sv */
// Partner: board reset supervisor and strap pins
`timescale 1ns/1ps
module board_supervisor (
    input wire logic clk,
    output logic rst_n,
    output logic wkp,
    output logic boot
);
    initial begin
        rst_n = 1'b1;
        wkp = 1'b0;
        boot = 1'b0;
    end
    task automatic pulse(input int len);
        rst_n <= 1'b0;
        repeat (len) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic straps(input logic [1:0] v);
        {boot, wkp} <= v;
    endtask
endmodule

/* File: reset_pin_filter_and_output_test.sv */
// Testbench: reset pin filter against a bench model
`timescale 1ns/1ps
module reset_pin_filter_and_output_test;
    localparam int HOLD = 10;
    localparam int LIMIT = 3000;
    logic MCLK, NRST, RESET_IN_N, INT_RESET_REQ, INT_RESET_NOWKP, WEAK_PULL_CONFIG_PIN, BOOT_CONFIG_PIN;
    logic RESET_OUT_N, RESET_OUT_OE, INTERNAL_RESET, BOOT_MODE;
    logic [5:0] RESET_STATUS_REG;
    int error_cnt = 0, comparisons = 0, cyc = 0, ir = 0, lo = 0, oe_lo = 0, ir0, lo0;
    logic [7:0] rnd = 8'h44;
    logic wkp_m = 1'b0, gl_m = 1'b0;
    board_supervisor sup (.clk(MCLK), .rst_n(RESET_IN_N), .wkp(WEAK_PULL_CONFIG_PIN), .boot(BOOT_CONFIG_PIN));
    reset_pin_filter_and_output #(.HOLD(HOLD)) dut (
        .MCLK(MCLK),
        .NRST(NRST),
        .RESET_IN_N(RESET_IN_N),
        .INT_RESET_REQ(INT_RESET_REQ),
        .INT_RESET_NOWKP(INT_RESET_NOWKP),
        .WEAK_PULL_CONFIG_PIN(WEAK_PULL_CONFIG_PIN),
        .BOOT_CONFIG_PIN(BOOT_CONFIG_PIN),
        .RESET_OUT_N(RESET_OUT_N),
        .RESET_OUT_OE(RESET_OUT_OE),
        .INTERNAL_RESET(INTERNAL_RESET),
        .RESET_STATUS_REG(RESET_STATUS_REG),
        .BOOT_MODE(BOOT_MODE)
    );
    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        ir <= ir + int'(INTERNAL_RESET === 1'b1);
        lo <= lo + int'(RESET_OUT_N === 1'b0);
        oe_lo <= oe_lo + int'(NRST === 1'b1 && RESET_OUT_OE !== 1'b1);
        if (cyc == LIMIT) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", name, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Pin pulse or internal request, then checks against the model
    task automatic run(input int len, input logic nowkp, input int again);
        int lo_run;
        rnd = lfsr(rnd);
        sup.straps(rnd[1:0]);
        @(negedge MCLK);
        ir0 = ir;
        lo0 = lo;
        @(posedge MCLK);
        if (len > 0) begin
            sup.pulse(len);
        end else begin
            INT_RESET_REQ <= 1'b1;
            INT_RESET_NOWKP <= nowkp;
            @(posedge MCLK);
            INT_RESET_REQ <= 1'b0;
        end
        if (again > 0) begin
            repeat (again) @(posedge MCLK);
            sup.pulse(3);
        end
        repeat (60) @(posedge MCLK);
        lo_run = lo - lo0;
        gl_m |= (len > 2 && len < 10) || again > 0;
        if (len == 0 || len > 9) begin
            if (!nowkp) wkp_m = rnd[0];
            chk("status", {2'h0, nowkp, gl_m, rnd[1], wkp_m, len == 0, len > 0}, {2'h0, RESET_STATUS_REG});
            chk("boot", {7'h0, rnd[1]}, {7'h0, BOOT_MODE});
        end
        if (again > 0) begin
            chk("restart", 8'h01, {7'h0, lo_run > HOLD});
        end else begin
            chk("low_time", 8'((len == 0 || len > 9) ? HOLD : 0), 8'(lo_run));
        end
        chk("reset", {7'h0, len == 0 || len > 9}, {7'h0, ir > ir0});
        chk("glitch", {7'h0, gl_m}, {7'h0, RESET_STATUS_REG[4]});
    endtask
    initial begin
        NRST = 1'b0;
        INT_RESET_REQ = 1'b0;
        INT_RESET_NOWKP = 1'b0;
        repeat (10) @(posedge MCLK);
        NRST <= 1'b1;
        run(1, 1'b0, 0);
        run(2, 1'b0, 0);
        run(3, 1'b0, 0);
        run(9, 1'b0, 0);
        run(10, 1'b0, 0);
        run(0, 1'b0, 0);
        run(0, 1'b1, 0);
        run(12, 1'b0, 0);
        run(12, 1'b0, 6);
        NRST <= 1'b0;
        repeat (2) @(posedge MCLK);
        NRST <= 1'b1;
        gl_m = 1'b0;
        wkp_m = 1'b0;
        @(negedge MCLK);
        chk("cleared", 8'h00, {2'h0, RESET_STATUS_REG});
        run(11, 1'b0, 0);
        chk("oe_low", 8'h00, 8'(oe_lo));
        report_and_stop();
    end
endmodule
